// >>> src/flash_host_pkg.sv
package flash_host_pkg;

  // software register byte offsets
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_DATA   = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_RDATA  = 5'h10;

  // status register bit positions
  localparam int STS_BUSY     = 0;
  localparam int STS_WORD_REQ = 1;
  localparam int STS_BUF_MODE = 2;
  localparam int STS_EXT_MODE = 3;
  localparam int STS_LOCK     = 4;
  localparam int STS_ABORTED  = 5;
  localparam int STS_REFUSED  = 6;
  localparam int STS_TOGGLING = 7;

  // flash status bits on the data bus
  localparam int BUFFER_ABORT_FLAG    = 1;
  localparam int OPERATION_ERROR_FLAG = 5;
  localparam int TOGGLE_FLAG          = 6;
  localparam int DATA_POLL_FLAG       = 7;

  // command cycle addresses and data codes
  localparam logic [23:0] UNLOCK_ADDR1     = 24'h00_0555;
  localparam logic [23:0] UNLOCK_ADDR2     = 24'h00_02aa;
  localparam logic [15:0] CODE_UNLOCK1     = 16'h00aa;
  localparam logic [15:0] CODE_UNLOCK2     = 16'h0055;
  localparam logic [15:0] CODE_BUF_ENTRY   = 16'h0038;
  localparam logic [15:0] CODE_BUF_SETUP   = 16'h0033;
  localparam logic [15:0] CODE_CONFIRM     = 16'h0029;
  localparam logic [15:0] CODE_ABORT_RESET = 16'h00f0;
  localparam logic [15:0] CODE_EXIT1       = 16'h0090;
  localparam logic [15:0] CODE_EXIT2       = 16'h0000;
  localparam logic [15:0] CODE_LOCK_ENTRY  = 16'h0040;
  localparam logic [15:0] CODE_EXT_ENTRY   = 16'h0088;

  // sequence lengths in bus writes, and the index of the confirm write
  localparam logic [8:0] LEN_UNLOCK3  = 9'h003;
  localparam logic [8:0] LEN_EXIT_EXT = 9'h004;
  localparam logic [8:0] LEN_EXIT2    = 9'h002;
  localparam logic [8:0] LEN_PROG     = 9'h102;
  localparam logic [8:0] LEN_SINGLE   = 9'h001;
  localparam logic [8:0] IDX_CONFIRM  = 9'h101;

  // bus timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WE_LOW_NS     = 35;
  localparam int RD_ACCESS_NS  = 80;
  localparam int SYNC_STAGES   = 3;
  localparam int WE_LOW_RAW    = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] WE_LOW_CYC = 3'(WE_LOW_RAW < 1 ? 1 : WE_LOW_RAW);
  localparam logic [2:0] RD_WAIT_CYC =
    3'((RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_ENTER_BUF = 4'h1,
    CMD_BUF_PROG  = 4'h2,
    CMD_ABORT     = 4'h3,
    CMD_EXIT_BUF  = 4'h4,
    CMD_ENTER_LCK = 4'h5,
    CMD_ENTER_EXT = 4'h6,
    CMD_EXIT_EXT  = 4'h7,
    CMD_EXIT_PROT = 4'h8,
    CMD_READ      = 4'h9,
    CMD_WRITE_RAW = 4'ha
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_LOAD    = 3'b001,
    ST_WR_SET  = 3'b010,
    ST_WR_LOW  = 3'b011,
    ST_WR_HOLD = 3'b100,
    ST_RD_WAIT = 3'b101
  } state_t;

endpackage

// >>> src/flash_host.sv
// Contract
// - entry: AA@555, 55@2AA, 38@555; mode persists
// - host polls toggle bit after entry; flash_host goes idle after the third entry write without polling
// - exit: 90 then 00, back to read
// - program: setup 33, 256 loads, confirm 29
// - loads ascend low byte 00 to FF
// - after abort only abort reset accepted; flash_host also accepts a read while aborted
// - extended exit takes four writes
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // software register port
  input  wire logic [4:0]  sw_addr_in,
  input  wire logic [31:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic      [31:0] sw_rdata_out,
  // flash pins
  output logic      [23:0] flash_addr_out,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n_out,
  output logic             flash_we_n_out,
  output logic             flash_oe_n_out
);

  typedef struct packed {
    flash_host_pkg::state_t st;
    flash_host_pkg::cmd_t   cmd;
    logic [8:0]             idx;
    logic [2:0]             cnt;
    logic [23:0]            base;
    logic [15:0]            word;
    logic                   word_valid;
    logic [23:0]            addr;
    logic [15:0]            dout;
    logic                   dq_oe;
    logic                   ce_n;
    logic                   we_n;
    logic                   oe_n;
    logic [15:0]            s1;
    logic [15:0]            s2;
    logic [15:0]            s3;
    logic [15:0]            filt;
    logic [15:0]            rword;
    logic                   buf_mode;
    logic                   ext_mode;
    logic                   lock_mode;
    logic                   aborted;
    logic                   refused;
    logic                   toggling;
    logic [31:0]            rdata;
  } ctl_t;

  ctl_t q;
  ctl_t d;

  flash_host_pkg::cmd_t req_cmd;
  logic                 go;
  logic                 ok;
  logic                 need_word;
  logic [39:0]          stp;

  function automatic logic [39:0] step(input flash_host_pkg::cmd_t c, input logic [8:0] i,
                                       input logic [23:0] b, input logic [15:0] w);
    logic [23:0] a;
    logic [15:0] v;
    logic [8:0]  k;
    a = flash_host_pkg::UNLOCK_ADDR1;
    v = flash_host_pkg::CODE_UNLOCK1;
    k = i - 9'h001;
    case (c)
      flash_host_pkg::CMD_ENTER_BUF, flash_host_pkg::CMD_ABORT, flash_host_pkg::CMD_ENTER_LCK,
      flash_host_pkg::CMD_ENTER_EXT, flash_host_pkg::CMD_EXIT_EXT: begin
        if (i == 9'h001) begin
          a = flash_host_pkg::UNLOCK_ADDR2;
          v = flash_host_pkg::CODE_UNLOCK2;
        end else if (i == 9'h002) begin
          case (c)
            flash_host_pkg::CMD_ENTER_BUF: v = flash_host_pkg::CODE_BUF_ENTRY;
            flash_host_pkg::CMD_ABORT:     v = flash_host_pkg::CODE_ABORT_RESET;
            flash_host_pkg::CMD_ENTER_LCK: v = flash_host_pkg::CODE_LOCK_ENTRY;
            flash_host_pkg::CMD_ENTER_EXT: v = flash_host_pkg::CODE_EXT_ENTRY;
            default:                       v = flash_host_pkg::CODE_EXIT1;
          endcase
        end else if (i == 9'h003) begin
          a = b;
          v = flash_host_pkg::CODE_EXIT2;
        end
      end
      flash_host_pkg::CMD_EXIT_BUF, flash_host_pkg::CMD_EXIT_PROT: begin
        a = b;
        v = (i == 9'h000) ? flash_host_pkg::CODE_EXIT1 : flash_host_pkg::CODE_EXIT2;
      end
      flash_host_pkg::CMD_BUF_PROG: begin
        a = {b[23:8], 8'h00};
        if (i == 9'h000) begin
          v = flash_host_pkg::CODE_BUF_SETUP;
        end else if (i == flash_host_pkg::IDX_CONFIRM) begin
          v = flash_host_pkg::CODE_CONFIRM;
        end else begin
          a = {b[23:8], k[7:0]};
          v = w;
        end
      end
      flash_host_pkg::CMD_WRITE_RAW: begin
        a = b;
        v = w;
      end
      default: ;
    endcase
    return {a, v};
  endfunction

  function automatic logic [8:0] seq_len(input flash_host_pkg::cmd_t c);
    case (c)
      flash_host_pkg::CMD_ENTER_BUF, flash_host_pkg::CMD_ABORT,
      flash_host_pkg::CMD_ENTER_LCK, flash_host_pkg::CMD_ENTER_EXT: return flash_host_pkg::LEN_UNLOCK3;
      flash_host_pkg::CMD_EXIT_EXT:  return flash_host_pkg::LEN_EXIT_EXT;
      flash_host_pkg::CMD_EXIT_BUF, flash_host_pkg::CMD_EXIT_PROT: return flash_host_pkg::LEN_EXIT2;
      flash_host_pkg::CMD_BUF_PROG:  return flash_host_pkg::LEN_PROG;
      default:                       return flash_host_pkg::LEN_SINGLE;
    endcase
  endfunction

  // mode gate: the far end ignores foreign sequences silently, so refuse them here
  function automatic logic cmd_ok(input ctl_t s, input flash_host_pkg::cmd_t c);
    if (c == flash_host_pkg::CMD_READ) return 1'b1;
    if (s.aborted) return c == flash_host_pkg::CMD_ABORT;
    if (s.buf_mode) return c == flash_host_pkg::CMD_BUF_PROG || c == flash_host_pkg::CMD_ABORT ||
                           c == flash_host_pkg::CMD_EXIT_BUF;
    if (s.lock_mode) return c == flash_host_pkg::CMD_WRITE_RAW || c == flash_host_pkg::CMD_EXIT_PROT;
    if (s.ext_mode) return c == flash_host_pkg::CMD_WRITE_RAW ||
                           c == flash_host_pkg::CMD_EXIT_EXT;
    return c == flash_host_pkg::CMD_ENTER_BUF || c == flash_host_pkg::CMD_ENTER_LCK ||
           c == flash_host_pkg::CMD_ENTER_EXT || c == flash_host_pkg::CMD_WRITE_RAW;
  endfunction

  assign req_cmd   = flash_host_pkg::cmd_t'(sw_wdata_in[3:0]);
  assign go        = sw_wr_in && sw_addr_in == flash_host_pkg::REG_CMD;
  assign ok        = q.st == flash_host_pkg::ST_IDLE && cmd_ok(q, req_cmd);
  assign need_word = q.cmd == flash_host_pkg::CMD_BUF_PROG && q.idx != 9'h000 &&
                     q.idx != flash_host_pkg::IDX_CONFIRM;
  assign stp       = step(q.cmd, q.idx, q.base, q.word);

  always_comb begin
    d = q;
    d.s1 = flash_dq_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.filt = q.s3;
    end
    d.rdata = 32'h0000_0000;
    if (sw_rd_in) begin
      case (sw_addr_in)
        flash_host_pkg::REG_ADDR:  d.rdata = {8'h00, q.base};
        flash_host_pkg::REG_RDATA: d.rdata = {16'h0000, q.rword};
        flash_host_pkg::REG_STATUS: begin
          d.rdata[flash_host_pkg::STS_BUSY]     = q.st != flash_host_pkg::ST_IDLE;
          d.rdata[flash_host_pkg::STS_WORD_REQ] = need_word && !q.word_valid &&
                                                  q.st == flash_host_pkg::ST_LOAD;
          d.rdata[flash_host_pkg::STS_BUF_MODE] = q.buf_mode;
          d.rdata[flash_host_pkg::STS_EXT_MODE] = q.ext_mode;
          d.rdata[flash_host_pkg::STS_LOCK]     = q.lock_mode;
          d.rdata[flash_host_pkg::STS_ABORTED]  = q.aborted;
          d.rdata[flash_host_pkg::STS_REFUSED]  = q.refused;
          d.rdata[flash_host_pkg::STS_TOGGLING] = q.toggling;
          d.refused = 1'b0;
        end
        default: ;
      endcase
    end
    if (sw_wr_in && sw_addr_in == flash_host_pkg::REG_ADDR) begin
      d.base = sw_wdata_in[23:0];
    end
    // a data word written while one is still pending is dropped
    if (sw_wr_in && sw_addr_in == flash_host_pkg::REG_DATA && !q.word_valid) begin
      d.word       = sw_wdata_in[15:0];
      d.word_valid = 1'b1;
    end
    if (go && !ok) begin
      d.refused = 1'b1;
    end
    case (q.st)
      flash_host_pkg::ST_IDLE: begin
        if (go && ok) begin
          d.cmd = req_cmd;
          d.idx = 9'h000;
          if (req_cmd == flash_host_pkg::CMD_READ) begin
            d.addr = q.base;
            d.ce_n = 1'b0;
            d.oe_n = 1'b0;
            d.cnt  = flash_host_pkg::RD_WAIT_CYC;
            d.st   = flash_host_pkg::ST_RD_WAIT;
          end else begin
            d.st = flash_host_pkg::ST_LOAD;
          end
        end
      end
      flash_host_pkg::ST_LOAD: begin
        if (!need_word || q.word_valid) begin
          d.addr  = stp[39:16];
          d.dout  = stp[15:0];
          d.ce_n  = 1'b0;
          d.dq_oe = 1'b1;
          d.st    = flash_host_pkg::ST_WR_SET;
          // a raw write uses up the pending word too, or the next word would be dropped
          if (need_word || q.cmd == flash_host_pkg::CMD_WRITE_RAW) begin
            d.word_valid = 1'b0;
          end
        end
      end
      flash_host_pkg::ST_WR_SET: begin
        d.we_n = 1'b0;
        d.cnt  = flash_host_pkg::WE_LOW_CYC - 3'h1;
        d.st   = flash_host_pkg::ST_WR_LOW;
      end
      flash_host_pkg::ST_WR_LOW: begin
        if (q.cnt == 3'h0) begin
          d.we_n = 1'b1;
          d.st   = flash_host_pkg::ST_WR_HOLD;
        end else begin
          d.cnt = q.cnt - 3'h1;
        end
      end
      flash_host_pkg::ST_WR_HOLD: begin
        d.ce_n  = 1'b1;
        d.dq_oe = 1'b0;
        d.idx   = q.idx + 9'h001;
        d.st    = flash_host_pkg::ST_LOAD;
        if (q.idx + 9'h001 == seq_len(q.cmd)) begin
          d.st = flash_host_pkg::ST_IDLE;
          case (q.cmd)
            flash_host_pkg::CMD_ENTER_BUF: d.buf_mode = 1'b1;
            flash_host_pkg::CMD_EXIT_BUF:  d.buf_mode = 1'b0;
            flash_host_pkg::CMD_ABORT:     d.aborted = 1'b0;
            flash_host_pkg::CMD_ENTER_LCK: d.lock_mode = 1'b1;
            flash_host_pkg::CMD_EXIT_PROT: d.lock_mode = 1'b0;
            flash_host_pkg::CMD_ENTER_EXT: d.ext_mode = 1'b1;
            flash_host_pkg::CMD_EXIT_EXT:  d.ext_mode = 1'b0;
            default: ;
          endcase
        end
      end
      flash_host_pkg::ST_RD_WAIT: begin
        if (q.cnt == 3'h0) begin
          d.rword    = q.filt;
          d.toggling = q.filt[flash_host_pkg::TOGGLE_FLAG] != q.rword[flash_host_pkg::TOGGLE_FLAG];
          d.ce_n     = 1'b1;
          d.oe_n     = 1'b1;
          d.st       = flash_host_pkg::ST_IDLE;
          // array data can mimic the flags; only a toggling status word means abort
          if (q.buf_mode && d.toggling && q.filt[flash_host_pkg::BUFFER_ABORT_FLAG] &&
              !q.filt[flash_host_pkg::OPERATION_ERROR_FLAG]) begin
            d.aborted = 1'b1;
          end
        end else begin
          d.cnt = q.cnt - 3'h1;
        end
      end
      default: d.st = flash_host_pkg::ST_IDLE;
    endcase
    if (!rst_n_in) begin
      d      = '0;
      d.ce_n = 1'b1;
      d.we_n = 1'b1;
      d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    q <= d;
  end

  assign sw_rdata_out    = q.rdata;
  assign flash_addr_out  = q.addr;
  assign flash_dq_out    = q.dout;
  assign flash_dq_oe_out = q.dq_oe;
  assign flash_ce_n_out  = q.ce_n;
  assign flash_we_n_out  = q.we_n;
  assign flash_oe_n_out  = q.oe_n;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_WE_INSIDE_CE: assert property (!q.we_n |-> !q.ce_n && q.dq_oe && q.oe_n)
    else $error("write strobe outside chip enable");
  AST_WR_STABLE: assert property (q.st == flash_host_pkg::ST_WR_LOW |=> $stable(q.addr) &&
                                  $stable(q.dout))
    else $error("address or data moved while strobe low");
  AST_ENTRY_THIRD: assert property (q.st == flash_host_pkg::ST_WR_SET &&
    q.cmd == flash_host_pkg::CMD_ENTER_BUF && q.idx == 9'h002 |->
    q.addr == flash_host_pkg::UNLOCK_ADDR1 && q.dout == flash_host_pkg::CODE_BUF_ENTRY)
    else $error("wrong third entry cycle");
  AST_ENTRY_MODE: assert property (q.st == flash_host_pkg::ST_WR_HOLD &&
    q.cmd == flash_host_pkg::CMD_ENTER_BUF && q.idx == 9'h002 |=> q.buf_mode ##1 q.buf_mode)
    else $error("buffered mode not entered");
  AST_EXIT_CODES: assert property (q.st == flash_host_pkg::ST_WR_SET &&
    q.cmd == flash_host_pkg::CMD_EXIT_BUF |-> q.dout == (q.idx == 9'h000 ?
    flash_host_pkg::CODE_EXIT1 : flash_host_pkg::CODE_EXIT2))
    else $error("wrong exit code");
  AST_LOAD_ORDER: assert property (q.st == flash_host_pkg::ST_WR_SET && need_word |->
    q.addr[7:0] == 8'(q.idx - 9'h001) && q.addr[23:8] == q.base[23:8])
    else $error("buffer load out of order or off page");
  AST_CONFIRM: assert property (q.st == flash_host_pkg::ST_WR_SET &&
    q.cmd == flash_host_pkg::CMD_BUF_PROG && q.idx == flash_host_pkg::IDX_CONFIRM |->
    q.dout == flash_host_pkg::CODE_CONFIRM)
    else $error("confirm code missing");
  AST_ABORT_GATE: assert property (go && q.st == flash_host_pkg::ST_IDLE && q.aborted &&
    req_cmd != flash_host_pkg::CMD_ABORT && req_cmd != flash_host_pkg::CMD_READ |=>
    q.refused && q.st == flash_host_pkg::ST_IDLE)
    else $error("command accepted while aborted");
  AST_BUF_GATE: assert property (go && q.st == flash_host_pkg::ST_IDLE && q.buf_mode &&
    req_cmd == flash_host_pkg::CMD_ENTER_LCK |=> q.st == flash_host_pkg::ST_IDLE)
    else $error("foreign command in buffered mode");

  COV_PROG_DONE: cover property (q.st == flash_host_pkg::ST_WR_HOLD &&
    q.cmd == flash_host_pkg::CMD_BUF_PROG && q.idx == flash_host_pkg::IDX_CONFIRM);
  COV_ABORT: cover property ($rose(q.aborted));
  COV_EXT: cover property ($rose(q.ext_mode) ##[1:200] $fell(q.ext_mode));

endmodule
`default_nettype wire

// >>> verif/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // bus pins from the host
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] dq_host_in,
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  // makes the next load count as a bad one
  input  wire logic        inject_abort_in,
  // data bus towards the host
  output logic      [15:0] dq_out
);
  // one page of array only: the page bits are checked, not stored
  logic [15:0] mem [0:255];
  logic [15:0] buf_q [0:255];
  logic [15:0] ext_mem [0:127];
  logic [15:0] lock_reg_q = 16'hffff;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] page_q = 16'h0000;
  logic [15:0] rd_val;
  logic [8:0]  cnt_q = 9'h000;
  logic [1:0]  unl_q = 2'b00;
  logic        buf_mode_q = 1'b0;
  logic        loading_q = 1'b0;
  logic        aborted_q = 1'b0;
  logic        lock_q = 1'b0;
  logic        exit1_q = 1'b0;
  logic        tog_q = 1'b0;
  logic        ext_q = 1'b0;
  logic        prog_q = 1'b0;
  int          wr_count = 0;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
      ext_mem[i % 128] = 16'h0000;
    end
  end
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      wr_count <= wr_count + 1;
      unl_q <= (dq_host_in == 16'h00aa && addr_in == 24'h00_0555) ? 2'd1 :
               (dq_host_in == 16'h0055 && unl_q == 2'd1) ? 2'd2 : 2'd0;
      exit1_q <= (dq_host_in == 16'h0090);
      prog_q <= (dq_host_in == 16'h00a0);
      if (aborted_q) begin
        if (unl_q == 2'd2 && dq_host_in == 16'h00f0) aborted_q <= 1'b0;
      end else if (loading_q) begin
        if (cnt_q == 9'h100) begin
          loading_q <= 1'b0;
          if (dq_host_in == 16'h0029) begin
            for (int i = 0; i < 256; i++) mem[i] <= mem[i] | buf_q[i];
          end else begin
            aborted_q <= 1'b1;
          end
        end else if (inject_abort_in || addr_in[7:0] != cnt_q[7:0]
                     || addr_in[23:8] != page_q) begin
          aborted_q <= 1'b1;
          loading_q <= 1'b0;
        end else begin
          buf_q[addr_in[7:0]] <= dq_host_in;
          cnt_q <= cnt_q + 9'h001;
        end
      end else if (buf_mode_q || lock_q) begin
        if (buf_mode_q && dq_host_in == 16'h0033) begin
          loading_q <= 1'b1;
          page_q <= addr_in[23:8];
          cnt_q <= 9'h000;
        end
        if (lock_q && prog_q) begin
          // bits only ever clear, so a set protection bit cannot be undone
          lock_reg_q <= lock_reg_q & dq_host_in;
        end else if (exit1_q && dq_host_in == 16'h0000) begin
          buf_mode_q <= 1'b0;
          lock_q <= 1'b0;
        end
      end else if (ext_q) begin
        // only program and exit act here: erase, bypass and boost codes fall through
        if (prog_q) begin
          if (addr_in[23:16] == 8'h00) begin
            ext_mem[addr_in[6:0]] <= ext_mem[addr_in[6:0]] | dq_host_in;
          end
        end else if (exit1_q && dq_host_in == 16'h0000) begin
          ext_q <= 1'b0;
        end
      end else if (unl_q == 2'd2 && addr_in == 24'h00_0555) begin
        buf_mode_q <= (dq_host_in == 16'h0038);
        lock_q <= (dq_host_in == 16'h0040);
        ext_q <= (dq_host_in == 16'h0088);
      end
    end
  end
  // block 0 is taken as the lowest 64k words; the extra block aliases over it
  assign rd_val = aborted_q ? {8'h00, 1'b0, tog_q, 6'b00_0010} :
                  lock_q ? lock_reg_q :
                  (ext_q && addr_in[23:16] == 8'h00) ? ext_mem[addr_in[6:0]] :
                  mem[addr_in[7:0]];
  // a released bus shows the inverse of the last word, never a stale copy
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_val : ~last_q;
  always @(posedge oe_n_in) begin
    last_q <= rd_val;
    if (aborted_q) tog_q <= ~tog_q;
  end
endmodule
`default_nettype wire

// >>> verif/flash_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  sw_addr = 5'h00;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic        inject = 1'b0;
  logic [31:0] sw_rdata;
  logic [23:0] f_addr;
  logic [15:0] f_dout;
  logic [15:0] f_din;
  logic        f_oe;
  logic        f_ce_n;
  logic        f_we_n;
  logic        f_oe_n;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] d;
  int          n;
  flash_host u_flash_host (.ref_clk_in(clk), .rst_n_in(rst_n), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata),
    .flash_addr_out(f_addr), .flash_dq_out(f_dout), .flash_dq_oe_out(f_oe),
    .flash_dq_in(f_din), .flash_ce_n_out(f_ce_n), .flash_we_n_out(f_we_n),
    .flash_oe_n_out(f_oe_n));
  flash_dev_model u_flash_dev_model (.addr_in(f_addr), .dq_host_in(f_dout), .ce_n_in(f_ce_n),
    .we_n_in(f_we_n), .oe_n_in(f_oe_n), .inject_abort_in(inject), .dq_out(f_din));
  initial forever #25 clk = ~clk;
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  // poll a status bit until it reads the wanted level, bounded
  task automatic wait_bit(input int b, input logic lvl);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      rd_reg(5'h0c, d);
      ok = (d[b] === lvl);
    end
    chk(ok, 1'b1);
  endtask
  task automatic cmd(input logic [3:0] c);
    wr_reg(5'h00, {28'h000_0000, c});
    wait_bit(0, 1'b0);
  endtask
  task automatic prog(input logic pat);
    wr_reg(5'h04, 32'h0000_1200);
    wr_reg(5'h00, 32'h0000_0002);
    for (int i = 0; i < 256; i++) begin
      wait_bit(1, 1'b1);
      wr_reg(5'h08, pat ? {16'h0000, 8'(i), 8'h0f} : {16'h0000, 8'h5a, 8'(i)});
    end
    wait_bit(0, 1'b0);
  endtask
  task automatic raw(input logic [15:0] v);
    wr_reg(5'h08, {16'h0000, v});
    cmd(4'ha);
  endtask
  task automatic rd_at(output logic [31:0] v);
    cmd(4'h9);
    rd_reg(5'h10, v);
  endtask
  task automatic t_reset();
    rd_reg(5'h0c, d);
    chk(d, 32'h0000_0000);
    chk({f_ce_n, f_we_n, f_oe_n, f_oe}, 4'b1110);
    rd_reg(5'h14, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_enter();
    n = u_flash_dev_model.wr_count;
    cmd(4'h1);
    chk(d[2], 1'b1);
    chk(u_flash_dev_model.buf_mode_q, 1'b1);
    chk(u_flash_dev_model.wr_count - n, 3);
  endtask
  task automatic t_program();
    prog(1'b0);
    chk(u_flash_dev_model.mem[0], 16'h5a00);
    chk(u_flash_dev_model.mem[255], 16'h5aff);
    prog(1'b1);
    chk(d[2], 1'b1);
    wr_reg(5'h04, 32'h0000_1203);
    cmd(4'h9);
    rd_reg(5'h10, d);
    chk(d, 32'h0000_5a0f | 32'h0000_0303);
  endtask
  task automatic t_refuse();
    n = u_flash_dev_model.wr_count;
    wr_reg(5'h00, 32'h0000_0005);
    rd_reg(5'h0c, d);
    chk({d[6], d[4]}, 2'b10);
    rd_reg(5'h0c, d);
    chk(d[6], 1'b0);
    chk(u_flash_dev_model.wr_count - n, 0);
  endtask
  task automatic t_abort();
    inject <= 1'b1;
    prog(1'b0);
    inject <= 1'b0;
    chk(u_flash_dev_model.aborted_q, 1'b1);
    cmd(4'h9);
    rd_reg(5'h10, d);
    chk({d[5], d[1]}, 2'b01);
    cmd(4'h9);
    chk({d[7], d[5], d[2]}, 3'b111);
    wr_reg(5'h00, 32'h0000_0001);
    rd_reg(5'h0c, d);
    chk(d[6], 1'b1);
    cmd(4'h3);
    chk({d[5], d[2]}, 2'b01);
    chk(u_flash_dev_model.aborted_q, 1'b0);
  endtask
  task automatic t_modes();
    n = u_flash_dev_model.wr_count;
    cmd(4'h4);
    chk(d[2], 1'b0);
    chk(u_flash_dev_model.wr_count - n, 2);
    cmd(4'h5);
    chk({d[4], u_flash_dev_model.lock_q}, 2'b11);
    raw(16'h00a0);
    raw(16'hfff0);
    rd_at(d);
    chk(d, 32'h0000_fff0);
    raw(16'h00a0);
    raw(16'hffff);
    rd_at(d);
    chk(d, 32'h0000_fff0);
    cmd(4'h8);
    chk({d[4], u_flash_dev_model.lock_q}, 2'b00);
    n = u_flash_dev_model.wr_count;
    cmd(4'h6);
    chk({d[3], u_flash_dev_model.ext_q}, 2'b11);
    raw(16'h00a0);
    raw(16'h0c3c);
    rd_at(d);
    chk(d, 32'h0000_0c3c);
    cmd(4'h7);
    chk({d[3], u_flash_dev_model.ext_q}, 2'b00);
    chk(u_flash_dev_model.wr_count - n, 9);
    rd_at(d);
    chk(d, 32'h0000_5a0f);
    cmd(4'h6);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(5'h0c, d);
    chk(d, 32'h0000_0000);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_enter();
    t_program();
    t_refuse();
    t_abort();
    t_modes();
    finish_test();
  end
endmodule
`default_nettype wire
